// ===== opst_ram.sv
// Purpose: Shared constants and types of the overpower stage, and its small memory.
// Assumes: One clock; memory read data are registered, one cycle after the address.
// Notes:   The same memory module serves the power lag line and the fault record history, as two instances.
package opst_pkg;
  // Clock and time base
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS = 1000000;
  localparam int CYCLES_PER_MS = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SAMPLE_MS = 5;
  localparam int PRE_FAULT_MS = 20;
  localparam int PRE_START_MS = 200;
  localparam int BLOCK_LEAD_MS = 5;
  localparam int AVG_DEPTH = PRE_FAULT_MS / SAMPLE_MS;
  localparam int LAG_DEPTH = PRE_START_MS / SAMPLE_MS;
  localparam int HIST_DEPTH = 12;
  localparam int NUM_SETS = 8;
  // Pick-up hysteresis in percent of the threshold
  localparam logic [31:0] PCT_FULL = 32'h0000_0064;
  localparam logic [31:0] PCT_DROP = 32'h0000_0061;
  // Reset values; threshold in 0.01 kW steps, delay in 5 ms steps
  localparam logic [23:0] THR_DEFAULT = 24'h00_2710;
  localparam logic [15:0] DLY_DEFAULT = 16'h0014;
  localparam logic [5:0] EVMASK_RST = 6'h3f;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_EVMASK = 8'h04;
  localparam logic [7:0] A_CNTCLR = 8'h08;
  localparam logic [7:0] A_STATUS = 8'h0c;
  localparam logic [7:0] A_CNT = 8'h10;
  localparam logic [7:0] A_RATIO = 8'h1c;
  localparam logic [7:0] A_EXPECT = 8'h20;
  localparam logic [7:0] A_REMAIN = 8'h24;
  localparam logic [7:0] A_HIST_IDX = 8'h28;
  localparam logic [7:0] A_HIST = 8'h40;
  localparam logic [7:0] A_THR = 8'h60;
  localparam logic [7:0] A_DLY = 8'h80;
  // Control register fields
  localparam int C_MODE = 0;
  localparam int C_SIDE = 1;
  localparam int C_FORCE_EN = 2;
  localparam int C_FORCE_LO = 3;
  localparam int C_BLK_TEST = 5;
  // Event flag positions
  localparam int EV_START_ON = 0;
  localparam int EV_START_OFF = 1;
  localparam int EV_TRIP_ON = 2;
  localparam int EV_TRIP_OFF = 3;
  localparam int EV_BLK_ON = 4;
  localparam int EV_BLK_OFF = 5;
  // Condition codes and AXI response codes
  localparam logic [1:0] COND_NORMAL = 2'h0;
  localparam logic [1:0] COND_START = 2'h1;
  localparam logic [1:0] COND_TRIP = 2'h2;
  localparam logic [1:0] COND_BLOCKED = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_START = 4'h2,
    S_TRIP = 4'h4,
    S_BLOCK = 4'h8
  } opst_state_type;

  typedef struct packed {
    logic [5:0] flags;
    logic [31:0] stamp;
    logic [23:0] power;
  } opst_event_type;

  typedef struct packed {
    logic [31:0] stamp;
    logic [1:0] code;
    logic [23:0] pre_fault;
    logic [23:0] fault;
    logic [23:0] pre_start;
    logic [15:0] remain;
    logic [2:0] set_index;
  } opst_rec_type;
endpackage : opst_pkg

`timescale 1ns/100ps

module opst_ram #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 40,
  parameter int AW = 6
) (
  // Clock
  input wire logic clock,
  // Write side
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // Read side
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  // No reset on the array; the read register hides write-through races
  always_ff @(posedge clock) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : opst_ram

// ===== opst_stage.sv
// Purpose: One overpower protection stage with AXI4-Lite registers.
// Assumes: sample_valid marks each 5 ms power value and the program cycle start.
// Notes:   Outputs come from the state register.
//
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps

module opst_stage import opst_pkg::*; #(
  parameter int MS_CYCLES = CYCLES_PER_MS
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Measurement and blocking inputs
  input wire logic sample_valid,
  input wire logic [23:0] power_side_a,
  input wire logic [23:0] power_side_b,
  input wire logic [2:0] parameter_set_index,
  input wire logic block_in,
  // Stage outputs
  output logic start_out,
  output logic trip_out,
  output logic blocked_out,
  output logic block_indication,
  output logic [1:0] condition,
  output opst_event_type event_out,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef struct packed {
    opst_state_type st;
    logic pick;
    logic start_o;
    logic trip_o;
    logic blk_o;
    logic [15:0] rem;
    logic [23:0] fault_p;
    logic [AVG_DEPTH-1:0][23:0] avg_win;
    logic [5:0] lag_ptr;
    logic [3:0] hist_wptr;
    logic [3:0] hist_idx;
    logic [7:0] ctrl;
    logic [5:0] ev_mask;
    opst_event_type ev;
    logic [NUM_SETS-1:0][23:0] thr;
    logic [NUM_SETS-1:0][15:0] dly;
    logic [2:0][31:0] cnt;
    logic [15:0] ratio;
    logic [16:0] ms_cyc;
    logic [31:0] ms_time;
    logic aw_got;
    logic w_got;
    logic bvalid;
    logic rvalid;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } opst_core_type;

  localparam opst_core_type CORE_RST = '{st: S_IDLE, ctrl: CTRL_RST, ev_mask: EVMASK_RST,
    thr: {NUM_SETS{THR_DEFAULT}}, dly: {NUM_SETS{DLY_DEFAULT}}, default: '0};

  opst_core_type core_reg;
  opst_core_type core_next;
  logic hist_we;
  opst_rec_type hist_wrec;
  opst_rec_type hist_rrec;
  logic [23:0] lag_rdata;
  logic [3:0] hist_raddr;

  // Address window decode, shared by the read and the write path
  function automatic logic in_win(input logic [7:0] addr, input logic [7:0] base,
                                  input int unsigned words);
    in_win = (addr >= base) && (addr < 8'(base + 8'(words * 4)));
  endfunction : in_win

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      old[i*8 +: 8] = strb[i] ? data[i*8 +: 8] : old[i*8 +: 8];
    end
    merge = old;
  endfunction : merge

  function automatic logic mapped(input logic [7:0] addr);
    mapped = (addr[1:0] == 2'h0) && (addr <= A_HIST_IDX || in_win(addr, A_HIST, 5) ||
             in_win(addr, A_THR, NUM_SETS) || in_win(addr, A_DLY, NUM_SETS));
  endfunction : mapped

  // Lag line of past samples; the slot about to be overwritten is 200 ms old
  opst_ram #(.WIDTH(24), .DEPTH(LAG_DEPTH), .AW(6)) lag_ram (
    .clock(clock),
    .we(sample_valid),
    .waddr(core_reg.lag_ptr),
    .wdata(sample_valid ? (core_reg.ctrl[C_SIDE] ? power_side_b : power_side_a) : 24'h0),
    .raddr(core_reg.lag_ptr),
    .rdata(lag_rdata)
  );

  // Fault record history
  assign hist_raddr = core_reg.hist_idx;
  opst_ram #(.WIDTH($bits(opst_rec_type)), .DEPTH(HIST_DEPTH), .AW(4)) hist_ram (
    .clock(clock),
    .we(hist_we),
    .waddr(core_reg.hist_wptr),
    .wdata(hist_wrec),
    .raddr(hist_raddr),
    .rdata(hist_rrec)
  );

  // Next-state logic of the whole stage
  always_comb begin
    logic [23:0] pw;
    logic [23:0] thr;
    logic [15:0] dly;
    logic blk;
    logic pick_n;
    logic force_en;
    logic [25:0] sum;
    logic [31:0] q;
    logic [2:0] clr;
    logic [2:0] rise;
    logic [7:0] ra;
    logic [31:0] rd;
    logic [5:0] chg;
    logic [31:0] mw;
    pw = 24'h0;
    thr = 24'h0;
    dly = 16'h0;
    blk = 1'b0;
    pick_n = 1'b0;
    force_en = 1'b0;
    sum = 26'h0;
    q = 32'h0;
    clr = 3'h0;
    rise = 3'h0;
    ra = 8'h0;
    rd = 32'h0;
    chg = 6'h0;
    mw = 32'h0;
    core_next = core_reg;
    hist_we = 1'b0;
    hist_wrec = '0;
    // Millisecond stamp counter
    if (core_reg.ms_cyc == 17'(MS_CYCLES - 1)) begin
      core_next.ms_cyc = 17'h0;
      core_next.ms_time = core_reg.ms_time + 32'h1;
    end else begin
      core_next.ms_cyc = core_reg.ms_cyc + 17'h1;
    end
    pw = core_reg.ctrl[C_SIDE] ? power_side_b : power_side_a;
    thr = core_reg.thr[parameter_set_index];
    dly = core_reg.dly[parameter_set_index];
    force_en = core_reg.ctrl[C_FORCE_EN];
    blk = block_in | (force_en & core_reg.ctrl[C_BLK_TEST]);
    for (int i = 0; i < AVG_DEPTH; i++) begin
      sum = sum + 26'(core_reg.avg_win[i]);
    end
    // Evaluate once per program cycle, on each new power value
    if (sample_valid) begin
      if (pw > thr) begin
        pick_n = 1'b1;
      end else if ({8'h0, pw} * PCT_FULL < {8'h0, thr} * PCT_DROP) begin
        pick_n = 1'b0;
      end else begin
        pick_n = core_reg.pick;
      end
      core_next.pick = pick_n;
      // Ratio in hundredths, saturated; a zero threshold reads as full scale
      q = (thr == 24'h0) ? 32'hffff_ffff : ({8'h0, pw} * PCT_FULL) / {8'h0, thr};
      core_next.ratio = (q > 32'h0000_ffff) ? 16'hffff : q[15:0];
      case (core_reg.st)
        S_IDLE: begin
          if (pick_n) begin
            core_next.fault_p = pw;
            if (blk) begin
              core_next.st = S_BLOCK;
            end else if (!core_reg.ctrl[C_MODE]) begin
              core_next.st = S_TRIP;
            end else begin
              core_next.st = S_START;
              core_next.rem = dly;
            end
          end
        end
        S_START: begin
          if (!pick_n || blk) begin
            core_next.st = S_IDLE;
            core_next.rem = 16'h0;
          end else if (core_reg.rem <= 16'h1) begin
            core_next.st = S_TRIP;
            core_next.rem = 16'h0;
          end else begin
            core_next.rem = core_reg.rem - 16'h1;
          end
        end
        S_TRIP: begin
          if (!pick_n || blk) begin
            core_next.st = S_IDLE;
          end
        end
        S_BLOCK: begin
          // Leave blocked on drop-out or release; re-evaluated as a fresh pick-up
          if (!pick_n || !blk) begin
            core_next.st = S_IDLE;
          end
        end
        default: begin
          core_next.st = S_IDLE;
        end
      endcase
      core_next.avg_win = {core_reg.avg_win[AVG_DEPTH-2:0], pw};
      core_next.lag_ptr = (core_reg.lag_ptr == 6'(LAG_DEPTH - 1)) ? 6'h0 :
                          core_reg.lag_ptr + 6'h1;
    end
    // Outputs; forcing overrides the state only while enabled
    if (force_en) begin
      core_next.start_o = core_reg.ctrl[C_FORCE_LO +: 2] inside {COND_START, COND_TRIP};
      core_next.trip_o = core_reg.ctrl[C_FORCE_LO +: 2] == COND_TRIP;
      core_next.blk_o = core_reg.ctrl[C_FORCE_LO +: 2] == COND_BLOCKED;
    end else begin
      core_next.start_o = core_next.st inside {S_START, S_TRIP};
      core_next.trip_o = core_next.st == S_TRIP;
      core_next.blk_o = core_next.st == S_BLOCK;
    end
    // Transitions become events sharing one stamp
    rise = {core_next.blk_o & ~core_reg.blk_o, core_next.trip_o & ~core_reg.trip_o,
            core_next.start_o & ~core_reg.start_o};
    chg = {~core_next.blk_o & core_reg.blk_o, rise[2],
           ~core_next.trip_o & core_reg.trip_o, rise[1],
           ~core_next.start_o & core_reg.start_o, rise[0]};
    core_next.ev.flags = chg & core_reg.ev_mask;
    core_next.ev.stamp = core_reg.ms_time;
    core_next.ev.power = rise[2] ? core_next.fault_p : pw;
    // One record per on transition; trip outranks start in the instant case
    if (|rise) begin
      hist_we = 1'b1;
      hist_wrec.stamp = core_reg.ms_time;
      hist_wrec.code = rise[1] ? COND_TRIP : (rise[0] ? COND_START : COND_BLOCKED);
      hist_wrec.pre_fault = sum[25:2];
      hist_wrec.fault = core_next.fault_p;
      hist_wrec.pre_start = lag_rdata;
      hist_wrec.remain = core_reg.rem;
      hist_wrec.set_index = parameter_set_index;
      core_next.hist_wptr = (core_reg.hist_wptr == 4'(HIST_DEPTH - 1)) ? 4'h0 :
                            core_reg.hist_wptr + 4'h1;
    end
    // AXI write: address and data taken in either order, answered together
    if (s_axi_awvalid && s_axi_awready) begin
      core_next.aw_got = 1'b1;
      core_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      core_next.w_got = 1'b1;
      core_next.wdata = s_axi_wdata;
      core_next.wstrb = s_axi_wstrb;
    end
    if (core_reg.aw_got && core_reg.w_got) begin
      core_next.aw_got = 1'b0;
      core_next.w_got = 1'b0;
      core_next.bvalid = 1'b1;
      core_next.bresp = mapped(core_reg.awaddr) ? RESP_OKAY : RESP_SLVERR;
      ra = core_reg.awaddr;
      if (ra == A_CTRL) begin
        mw = merge({24'h0, core_reg.ctrl}, core_reg.wdata, core_reg.wstrb);
        core_next.ctrl = mw[7:0];
      end else if (ra == A_EVMASK) begin
        core_next.ev_mask = core_reg.wstrb[0] ? core_reg.wdata[5:0] : core_reg.ev_mask;
      end else if (ra == A_CNTCLR) begin
        clr = core_reg.wstrb[0] ? core_reg.wdata[2:0] : 3'h0;
      end else if (ra == A_HIST_IDX) begin
        core_next.hist_idx = core_reg.wstrb[0] ? core_reg.wdata[3:0] : core_reg.hist_idx;
      end else if (in_win(ra, A_THR, NUM_SETS)) begin
        mw = merge({8'h0, core_reg.thr[ra[4:2]]}, core_reg.wdata, core_reg.wstrb);
        core_next.thr[ra[4:2]] = mw[23:0];
      end else if (in_win(ra, A_DLY, NUM_SETS)) begin
        mw = merge({16'h0, core_reg.dly[ra[4:2]]}, core_reg.wdata, core_reg.wstrb);
        core_next.dly[ra[4:2]] = mw[15:0];
      end
    end
    if (core_reg.bvalid && s_axi_bready) begin
      core_next.bvalid = 1'b0;
    end
    // Counters; a count in the clearing cycle survives as one
    for (int i = 0; i < 3; i++) begin
      if (rise[i]) begin
        core_next.cnt[i] = clr[i] ? 32'h1 : core_reg.cnt[i] + 32'h1;
      end else if (clr[i]) begin
        core_next.cnt[i] = 32'h0;
      end
    end
    // AXI read, answered the cycle after the address is taken
    if (s_axi_arvalid && s_axi_arready) begin
      ra = s_axi_araddr;
      if (ra == A_CTRL) begin
        rd = {24'h0, core_reg.ctrl};
      end else if (ra == A_EVMASK) begin
        rd = {26'h0, core_reg.ev_mask};
      end else if (ra == A_STATUS) begin
        rd = {27'h0, core_reg.blk_o, core_reg.trip_o, core_reg.start_o, condition};
      end else if (in_win(ra, A_CNT, 3)) begin
        rd = core_reg.cnt[ra[3:2]];
      end else if (ra == A_RATIO) begin
        rd = {16'h0, core_reg.ratio};
      end else if (ra == A_EXPECT) begin
        rd = {16'h0, core_reg.ctrl[C_MODE] ? dly : 16'h0};
      end else if (ra == A_REMAIN) begin
        rd = {16'h0, core_reg.rem};
      end else if (ra == A_HIST_IDX) begin
        rd = {28'h0, core_reg.hist_idx};
      end else if (in_win(ra, A_HIST, 5)) begin
        case (ra[4:2])
          3'h0: rd = hist_rrec.stamp;
          3'h1: rd = {11'h0, hist_rrec.set_index, hist_rrec.code, hist_rrec.remain};
          3'h2: rd = {8'h0, hist_rrec.pre_fault};
          3'h3: rd = {8'h0, hist_rrec.fault};
          default: rd = {8'h0, hist_rrec.pre_start};
        endcase
      end else if (in_win(ra, A_THR, NUM_SETS)) begin
        rd = {8'h0, core_reg.thr[ra[4:2]]};
      end else if (in_win(ra, A_DLY, NUM_SETS)) begin
        rd = {16'h0, core_reg.dly[ra[4:2]]};
      end
      core_next.rvalid = 1'b1;
      core_next.rdata = mapped(ra) ? rd : 32'h0;
      core_next.rresp = mapped(ra) ? RESP_OKAY : RESP_SLVERR;
    end else if (core_reg.rvalid && s_axi_rready) begin
      core_next.rvalid = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      core_reg <= CORE_RST;
    end else begin
      core_reg <= core_next;
    end
  end

  // Port drive; single stage by construction
  assign start_out = core_reg.start_o;
  assign trip_out = core_reg.trip_o;
  assign blocked_out = core_reg.blk_o;
  assign block_indication = core_reg.blk_o;
  assign condition = core_reg.blk_o ? COND_BLOCKED : (core_reg.trip_o ? COND_TRIP :
                     (core_reg.start_o ? COND_START : COND_NORMAL));
  assign event_out = core_reg.ev;
  assign s_axi_awready = !core_reg.aw_got && !core_reg.bvalid;
  assign s_axi_wready = !core_reg.w_got && !core_reg.bvalid;
  assign s_axi_bvalid = core_reg.bvalid;
  assign s_axi_bresp = core_reg.bresp;
  assign s_axi_arready = !core_reg.rvalid;
  assign s_axi_rvalid = core_reg.rvalid;
  assign s_axi_rdata = core_reg.rdata;
  assign s_axi_rresp = core_reg.rresp;

  // Checks on the stage behaviour
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  instant_pair_a: assert property (
    $rose(start_out) && !$past(core_reg.ctrl[C_MODE]) && !$past(core_reg.ctrl[C_FORCE_EN])
    |-> trip_out && (event_out.flags[EV_TRIP_ON] == event_out.flags[EV_START_ON] ||
        $past(core_reg.ev_mask[EV_TRIP_ON]) != $past(core_reg.ev_mask[EV_START_ON])))
    else $error("instant start without trip");
  pickup_start_a: assert property (
    sample_valid && core_reg.st == S_IDLE && core_reg.ctrl[C_MODE] && !blk_any() &&
    power_now() > core_reg.thr[parameter_set_index] |=> core_reg.st == S_START)
    else $error("unblocked pick-up did not start");
  pickup_blocked_a: assert property (
    sample_valid && core_reg.st == S_IDLE && blk_any() &&
    power_now() > core_reg.thr[parameter_set_index] |=> core_reg.st == S_BLOCK ##0
    !(core_reg.st inside {S_START, S_TRIP}))
    else $error("blocked pick-up started");
  block_release_a: assert property (
    sample_valid && core_reg.st == S_START && blk_any() |=> core_reg.st == S_IDLE)
    else $error("block did not clear start");
  hold_band_a: assert property (
    sample_valid && core_reg.pick && {8'h0, power_now()} * PCT_FULL >=
    {8'h0, core_reg.thr[parameter_set_index]} * PCT_DROP |=> core_reg.pick)
    else $error("dropped out inside hysteresis");
  delay_end_a: assert property (
    sample_valid && core_reg.st == S_START && core_reg.rem == 16'h1 && !blk_any() &&
    power_now() > core_reg.thr[parameter_set_index] |=> core_reg.st == S_TRIP)
    else $error("delay expiry did not trip");
  event_off_a: assert property (
    $fell(blocked_out) && $past(core_reg.ev_mask[EV_BLK_OFF]) |-> event_out.flags[EV_BLK_OFF])
    else $error("blocked off event missing");
  trip_count_a: assert property (
    $rose(trip_out) && !$past(core_reg.aw_got && core_reg.w_got)
    |-> core_reg.cnt[1] == $past(core_reg.cnt[1]) + 32'h1)
    else $error("trip count not advanced");
  record_log_a: assert property (
    $rose(start_out) |-> core_reg.hist_wptr != $past(core_reg.hist_wptr))
    else $error("start not recorded");
  cond_code_a: assert property (
    trip_out && !blocked_out |-> condition == COND_TRIP)
    else $error("condition code wrong");

  trip_seen_c: cover property ($rose(start_out) ##[1:300] $rose(trip_out));
  block_seen_c: cover property ($rose(blocked_out));
  release_seen_c: cover property (core_reg.st == S_START ##1 core_reg.st == S_IDLE);

  function automatic logic blk_any();
    blk_any = block_in | (core_reg.ctrl[C_FORCE_EN] & core_reg.ctrl[C_BLK_TEST]);
  endfunction : blk_any

  function automatic logic [23:0] power_now();
    power_now = core_reg.ctrl[C_SIDE] ? power_side_b : power_side_a;
  endfunction : power_now
endmodule : opst_stage

// ===== opst_meas_model.sv
// Purpose: Measurement chain model giving one power sample per period.
// Assumes: Period shortened to PER cycles for simulation.
// Notes:   Side b stays at zero so a wrong side choice shows.
`timescale 1ns/100ps
module opst_meas_model #(parameter int PER = 20) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Bench level in, stage side out
  input wire logic [23:0] level,
  output logic sample_valid,
  output logic [23:0] power_side_a,
  output logic [23:0] power_side_b
);
  int cnt;
  // Fixed time base; level follows one edge late
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      sample_valid <= 1'b0;
      power_side_a <= 24'h0;
    end else begin
      cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
      sample_valid <= (cnt == PER - 1);
      power_side_a <= level;
    end
  end
  assign power_side_b = 24'h0;
endmodule : opst_meas_model

// ===== tb_opst_stage.sv
// Purpose: Self-checking bench for the overpower stage.
// Assumes: Stamp tick and sample period shortened for simulation.
// Notes:   Read results come back through rd_v and rs.
`timescale 1ns/100ps
module tb_opst_stage import opst_pkg::*; ();
  logic clock = 1'b0, rst_n = 1'b0, block_in = 1'b0, sample_valid;
  logic start_out, trip_out, blocked_out, block_indication;
  logic [2:0] parameter_set_index = 3'h0;
  logic [23:0] power_side_a, power_side_b, pw = 24'h0;
  logic [1:0] condition, s_axi_bresp, s_axi_rresp, rs;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_v;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  opst_event_type event_out;
  int n_errors = 0, check_count = 0;
  // 125 MHz clock
  always #4 clock = ~clock;
  opst_stage #(.MS_CYCLES(10)) dut (.clock(clock), .rst_n(rst_n),
    .sample_valid(sample_valid), .power_side_a(power_side_a), .power_side_b(power_side_b),
    .parameter_set_index(parameter_set_index), .block_in(block_in), .start_out(start_out),
    .trip_out(trip_out), .blocked_out(blocked_out), .block_indication(block_indication),
    .condition(condition), .event_out(event_out), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  opst_meas_model #(.PER(20)) meas (.clock(clock), .rst_n(rst_n), .level(pw),
    .sample_valid(sample_valid), .power_side_a(power_side_a), .power_side_b(power_side_b));
  // Verdict and end of run
  task test_done;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // One bus access, w high for write; each valid drops once taken
  task ax(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    for (i = 0; i < 50; i++) begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_bvalid || s_axi_rvalid) break;
    end
    rd_v = s_axi_rdata;
    rs = w ? s_axi_bresp : s_axi_rresp;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    if (i == 50) begin
      n_errors++;
      test_done();
    end
    // Idle edge, so a following call never re-raises a just-lowered signal
    @(posedge clock);
  endtask : ax
  // Wait n samples; first edge skipped so a fresh level is sampled
  task sp(input int n);
    int i;
    @(posedge clock);
    for (i = 0; i < 200 && n > 0; i++) begin
      @(posedge clock);
      if (sample_valid) n--;
    end
    @(posedge clock);
    if (n > 0) begin
      n_errors++;
      test_done();
    end
  endtask : sp
  // Main sequence
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    ax(1'b0, A_THR, 32'h0);
    chk(rd_v, {8'h0, THR_DEFAULT});
    ax(1'b0, 8'hfc, 32'h0);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    pw <= 24'h00_2711;
    sp(1);
    chk({30'h0, condition}, {30'h0, COND_TRIP});
    chk({26'h0, event_out.flags}, 32'h5);
    ax(1'b0, A_RATIO, 32'h0);
    chk(rd_v, 32'h64);
    ax(1'b0, A_HIST + 8'h04, 32'h0);
    chk(rd_v, {14'h0, COND_TRIP, 16'h0});
    pw <= 24'h00_25e4;
    sp(2);
    chk({30'h0, condition}, {30'h0, COND_TRIP});
    pw <= 24'h00_25e3;
    sp(1);
    chk({30'h0, condition}, {30'h0, COND_NORMAL});
    ax(1'b0, A_CNT + 8'h04, 32'h0);
    chk(rd_v, 32'h1);
    ax(1'b1, A_CNTCLR, 32'h2);
    ax(1'b0, A_CNT + 8'h04, 32'h0);
    chk(rd_v, 32'h0);
    ax(1'b1, A_CTRL, 32'h1);
    ax(1'b1, A_DLY, 32'h2);
    chk({30'h0, rs}, {30'h0, RESP_OKAY});
    pw <= 24'h00_2711;
    sp(2);
    chk({30'h0, condition}, {30'h0, COND_START});
    sp(1);
    chk({30'h0, condition}, {30'h0, COND_TRIP});
    pw <= 24'h0;
    sp(1);
    chk({30'h0, condition}, {30'h0, COND_NORMAL});
    block_in <= 1'b1; // Held well ahead of any delay end
    pw <= 24'h00_2711;
    sp(1);
    chk({30'h0, condition}, {30'h0, COND_BLOCKED});
    chk({30'h0, blocked_out, block_indication}, 32'h3);
    chk({8'h0, event_out.power}, 32'h0000_2711);
    chk({26'h0, event_out.flags}, 32'h10);
    block_in <= 1'b0;
    sp(2);
    chk({30'h0, condition}, {30'h0, COND_START});
    block_in <= 1'b1;
    sp(1);
    chk({31'h0, start_out}, 32'h0);
    ax(1'b1, A_THR + 8'h04, 32'h4e20);
    parameter_set_index <= 3'h1;
    block_in <= 1'b0;
    pw <= 24'h00_3a98;
    sp(3);
    chk({30'h0, condition}, {30'h0, COND_NORMAL});
    ax(1'b1, A_CTRL, 32'h19);
    chk({30'h0, condition}, {30'h0, COND_NORMAL});
    ax(1'b1, A_CTRL, 32'h1d);
    chk({30'h0, condition}, {30'h0, COND_BLOCKED});
    test_done();
  end
endmodule : tb_opst_stage
